// ==== shared/uvp_pkg.sv ====
// shared constants and types for the eprom programmer
package uvp_pkg;
   // geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam logic [16:0] LAST_ADDR = 17'h1_FFFF;
   localparam logic [7:0] ERASED_BYTE = 8'h00_FF;
   // clock and times
   localparam int CLK_HZ = 25_000_000;
   localparam int SETUP_US = 2;
   localparam int FAST_PW_US = 100;
   localparam int INTER_PW_US = 1000;
   localparam int OVER_PW_US = 2000;
   localparam int READ_NS = 400;
   localparam int SETUP_CYC = (SETUP_US * (CLK_HZ / 1_000_000));
   localparam int FAST_PW_CYC = (FAST_PW_US * (CLK_HZ / 1_000_000));
   localparam int INTER_PW_CYC = (INTER_PW_US * (CLK_HZ / 1_000_000));
   localparam int OVER_PW_CYC = (OVER_PW_US * (CLK_HZ / 1_000_000));
   localparam int READ_CYC = (READ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // pulse limits
   localparam int FAST_MAX_PULSES = 25;
   localparam int INTER_MAX_PULSES = 25;
   // supply level selections for the external regulators
   typedef enum logic [1:0] {
      UVP_VCC_NORMAL = 2'b00,
      UVP_VCC_INTER  = 2'b01,
      UVP_VCC_FAST   = 2'b10
   } uvp_vcc_t;
   typedef enum logic [1:0] {
      UVP_VPP_NORMAL = 2'b00,
      UVP_VPP_PROG   = 2'b01,
      UVP_VPP_FAST   = 2'b10
   } uvp_vpp_t;
   // operations
   typedef enum logic [1:0] {
      UVP_OP_INTER = 2'b00,
      UVP_OP_FAST  = 2'b01,
      UVP_OP_IDENT = 2'b10,
      UVP_OP_READ  = 2'b11
   } uvp_op_t;
   // odd parity check over an identification byte
   function automatic logic odd_parity(input logic [7:0] b);
      odd_parity = ^b;
   endfunction
endpackage

// ==== hw/uvp_delay.sv ====
// cycle timer that counts down a loaded length and flags its end
module uvp_delay #(
   parameter int CNT_W = 17
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // control
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] length,
   // status
   output logic                  done
);
   logic [CNT_W-1:0] count;
   logic             busy;

   // countdown; done pulses on the last cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count <= '0;
         busy  <= 1'b0;
      end
      else if (load)
      begin
         count <= length;
         busy  <= 1'b1;
      end
      else if (busy)
      begin
         count <= count - 1'b1;
         busy  <= (count > 1);
      end
   end

   assign done = busy && (count <= 1);
endmodule

// ==== hw/uvp_programmer.sv ====
// pin-level programmer for a byte-wide uv-erasable prom
// Operation
// - program mode is raised supply, gate high, select and strobe low.
// - full data byte is driven in parallel while programming.
// - interactive: verify after each pulse, repeat until match or limit.
// - interactive pulse and verify runs with core supply elevated.
// - after interactive success one overprogram pulse is added.
// - interactive ends with full verify at normal core supply.
// - fast setup applies fast supply levels with strobe high first.
// - fast pulse is one 100 us low strobe after lines settle.
// - fast programming gives at most 25 pulses per address.
// - fast ends with full verify, both supplies normal.
// - select pulse with raised supply and low strobe programs one memory.
// - verify: gate and select low, strobe high, supply raised, byte lines released.
// - identify: high voltage on line nine, other lines low except zero.
// - memory drives data only with select and gate both low.
module uvp_programmer #(
   parameter int FAST_PW   = uvp_pkg::FAST_PW_CYC,
   parameter int INTER_PW  = uvp_pkg::INTER_PW_CYC,
   parameter int OVER_PW   = uvp_pkg::OVER_PW_CYC,
   parameter int SETUP     = uvp_pkg::SETUP_CYC,
   parameter logic [16:0] LAST = uvp_pkg::LAST_ADDR
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // command port
   input  wire logic        START,
   input  wire logic [1:0]  OP,
   input  wire logic [16:0] RD_ADDR,
   output logic            BUSY,
   output logic            DONE,
   output logic            FAIL,
   output logic [16:0]     FAIL_ADDR,
   output logic [7:0]      RD_DATA,
   output logic [7:0]      ID_MAKER,
   output logic [7:0]      ID_DEVICE,
   output logic            ID_PARITY_OK,
   // source of bytes to program, looked up by address
   output logic [16:0]     SRC_ADDR,
   input  wire logic [7:0]  SRC_DATA,
   // memory pins
   output logic [16:0]     WORD_ADDRESS_LINES,
   output logic            ID_HIGH_VOLTAGE,
   output logic            CHIP_SELECT_N,
   output logic            OUTPUT_GATE_N,
   output logic            PROGRAM_STROBE_N,
   input  wire logic [7:0]  BYTE_LINES_IN,
   output logic [7:0]      BYTE_LINES_OUT,
   output logic            BYTE_LINES_OE,
   // supply selections
   output logic [1:0]      VCC_SEL,
   output logic [1:0]      VPP_SEL
);
   typedef enum logic [3:0] {
      S_IDLE   = 4'b0000,
      S_SETUP  = 4'b0001,
      S_PULSE  = 4'b0010,
      S_GAP    = 4'b0011,
      S_VERIFY = 4'b0100,
      S_CHECK  = 4'b0101,
      S_OVER   = 4'b0110,
      S_NEXT   = 4'b0111,
      S_FSET   = 4'b1000,
      S_FREAD  = 4'b1001,
      S_FCHECK = 4'b1010,
      S_READ   = 4'b1011,
      S_RCHECK = 4'b1100,
      S_END    = 4'b1101
   } uvp_state_t;

   uvp_state_t state;
   uvp_state_t next_state;
   logic [1:0]  op;
   logic [16:0] addr;
   logic [4:0]  pulses;
   logic        id_phase;
   logic [7:0]  sync1;
   logic [7:0]  sync2;
   logic        tload;
   logic [16:0] tlen;
   logic        tdone;
   logic        fast;
   logic        match;
   logic        last_addr;
   logic        limit;
   logic        final_pass;
   logic [4:0]  max_pulses;

   // byte lines pass two flip-flops before use
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= BYTE_LINES_IN;
         sync2 <= sync1;
      end
   end

   uvp_delay #(
      .CNT_W(17)
   ) u_delay (
      .clk    (CLK),
      .rst    (RST),
      .load   (tload),
      .length (tlen),
      .done   (tdone)
   );

   // decode of the current situation
   assign fast       = (op == uvp_pkg::UVP_OP_FAST);
   assign max_pulses = fast ? 5'(uvp_pkg::FAST_MAX_PULSES) : 5'(uvp_pkg::INTER_MAX_PULSES);
   assign match      = (sync2 == SRC_DATA);
   assign last_addr  = (addr == LAST);
   assign limit      = (pulses >= max_pulses);
   assign SRC_ADDR   = addr;
   assign BUSY       = (state != S_IDLE);

   // next state and timer loads
   always_comb
   begin
      next_state = state;
      tload      = 1'b0;
      tlen       = 17'(SETUP);
      case (state)
         S_IDLE:
         begin
            if (START)
            begin
               tload      = 1'b1;
               next_state = (OP == uvp_pkg::UVP_OP_IDENT || OP == uvp_pkg::UVP_OP_READ) ? S_READ :
                            (OP == uvp_pkg::UVP_OP_FAST) ? S_FSET : S_SETUP;
            end
         end
         S_SETUP, S_FSET, S_GAP:
         begin
            if (tdone)
            begin
               tload      = 1'b1;
               tlen       = (state == S_GAP) ? 17'(uvp_pkg::READ_CYC) + 17'(SETUP) :
                            (fast ? 17'(FAST_PW) : 17'(INTER_PW));
               next_state = (state == S_GAP) ? S_VERIFY : S_PULSE;
            end
         end
         S_PULSE, S_OVER:
         begin
            if (tdone)
            begin
               tload      = 1'b1;
               next_state = (state == S_OVER) ? S_NEXT : S_GAP;
            end
         end
         S_VERIFY:
         begin
            if (tdone)
               next_state = S_CHECK;
         end
         S_CHECK:
         begin
            tload = 1'b1;
            if (match)
            begin
               if (!fast)
               begin
                  tlen       = 17'(OVER_PW);
                  next_state = S_OVER;
               end
               else
                  next_state = S_NEXT;
            end
            else if (limit)
               next_state = S_END;
            else
               next_state = fast ? S_FSET : S_SETUP;
         end
         S_NEXT:
         begin
            tload      = 1'b1;
            next_state = last_addr ? S_FREAD : (fast ? S_FSET : S_SETUP);
         end
         S_FREAD:
         begin
            if (tdone)
            begin
               tlen       = 17'(uvp_pkg::READ_CYC) + 17'(SETUP);
               tload      = 1'b1;
               next_state = S_FCHECK;
            end
         end
         S_FCHECK:
         begin
            if (tdone)
            begin
               tload      = 1'b1;
               tlen       = 17'(uvp_pkg::READ_CYC) + 17'(SETUP); // new address settles and syncs
               next_state = (!match || last_addr) ? S_END : S_FCHECK;
            end
         end
         S_READ:
         begin
            if (tdone)
            begin
               tload      = 1'b1;
               next_state = S_RCHECK;
            end
         end
         S_RCHECK:
         begin
            if (tdone)
            begin
               tload      = (op == uvp_pkg::UVP_OP_IDENT) && !id_phase;
               tlen       = 17'(uvp_pkg::READ_CYC) + 17'(SETUP); // device byte settles and syncs
               next_state = tload ? S_RCHECK : S_END;
            end
         end
         S_END:
            next_state = S_IDLE;
         default:
            next_state = S_IDLE;
      endcase
   end

   // state, address stepping and pulse counting
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state      <= S_IDLE;
         op         <= uvp_pkg::UVP_OP_INTER;
         addr       <= '0;
         pulses     <= '0;
         id_phase   <= 1'b0;
         final_pass <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == S_IDLE && START)
         begin
            op         <= OP;
            addr       <= (OP == uvp_pkg::UVP_OP_READ) ? RD_ADDR : '0;
            pulses     <= '0;
            id_phase   <= 1'b0;
            final_pass <= 1'b0;
         end
         // count each S_PULSE pulse for this address
         if (state == S_PULSE && tdone)
            pulses <= pulses + 5'd1;
         if (state == S_NEXT)
         begin
            pulses <= '0;
            addr   <= last_addr ? '0 : addr + 17'd1;
            final_pass <= last_addr;
         end
         if (state == S_FCHECK && tdone && match && !last_addr)
            addr <= addr + 17'd1;
         if (state == S_RCHECK && tdone)
            id_phase <= 1'b1;
      end
   end

   // results captured from the byte lines
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         DONE         <= 1'b0;
         FAIL         <= 1'b0;
         FAIL_ADDR    <= '0;
         RD_DATA      <= uvp_pkg::ERASED_BYTE;
         ID_MAKER     <= '0;
         ID_DEVICE    <= '0;
         ID_PARITY_OK <= 1'b0;
      end
      else
      begin
         DONE <= (state == S_END);
         if (state == S_IDLE && START)
            FAIL <= 1'b0;
         if ((state == S_CHECK && !match && limit) || (state == S_FCHECK && tdone && !match))
         begin
            FAIL      <= 1'b1;
            FAIL_ADDR <= addr;
         end
         if (state == S_RCHECK && tdone)
         begin
            RD_DATA <= sync2;
            // line zero low gives maker byte, high gives device byte
            if (op == uvp_pkg::UVP_OP_IDENT && !id_phase)
               ID_MAKER <= sync2;
            if (op == uvp_pkg::UVP_OP_IDENT && id_phase)
            begin
               ID_DEVICE    <= sync2;
               // both bytes must be odd parity
               ID_PARITY_OK <= uvp_pkg::odd_parity(ID_MAKER) && uvp_pkg::odd_parity(sync2);
            end
         end
      end
   end

   // pin drive per state
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         WORD_ADDRESS_LINES <= '0;
         ID_HIGH_VOLTAGE    <= 1'b0;
         CHIP_SELECT_N      <= 1'b1;
         OUTPUT_GATE_N      <= 1'b1;
         PROGRAM_STROBE_N   <= 1'b1;
         BYTE_LINES_OUT     <= '0;
         BYTE_LINES_OE      <= 1'b0;
         VCC_SEL            <= uvp_pkg::UVP_VCC_NORMAL;
         VPP_SEL            <= uvp_pkg::UVP_VPP_NORMAL;
      end
      else
      begin
         // identify holds lines low except zero, high voltage on nine
         WORD_ADDRESS_LINES <= (op == uvp_pkg::UVP_OP_IDENT) ? {16'h0000, id_phase} : addr;
         // high voltage only once the new op has put the id address out
         ID_HIGH_VOLTAGE    <= (op == uvp_pkg::UVP_OP_IDENT) && (state == S_READ || state == S_RCHECK) &&
                               (next_state == S_READ || next_state == S_RCHECK);
         // byte driven in parallel only while writing
         BYTE_LINES_OUT     <= SRC_DATA;
         BYTE_LINES_OE      <= (next_state == S_SETUP || next_state == S_FSET || next_state == S_PULSE ||
                                next_state == S_OVER);
         // select low, gate high, strobe low during pulses
         // select stays low through each address's write, released for the S_NEXT step
         CHIP_SELECT_N      <= (next_state == S_IDLE || next_state == S_END || next_state == S_NEXT);
         // verify with gate low, strobe high
         // gate low only when reading back
         OUTPUT_GATE_N      <= !(next_state == S_VERIFY || next_state == S_CHECK || next_state == S_FCHECK ||
                                 next_state == S_READ || next_state == S_RCHECK);
         // single low strobe for the timed pulse
         PROGRAM_STROBE_N   <= !(next_state == S_PULSE || next_state == S_OVER);
         // elevated core supply while pulsing interactively
         // fast levels applied from setup on
         if (next_state == S_FREAD || next_state == S_FCHECK || next_state == S_IDLE ||
             next_state == S_READ || next_state == S_RCHECK || next_state == S_END)
         begin
            VCC_SEL <= uvp_pkg::UVP_VCC_NORMAL;
            VPP_SEL <= uvp_pkg::UVP_VPP_NORMAL;
         end
         else
         begin
            VCC_SEL <= fast ? uvp_pkg::UVP_VCC_FAST : uvp_pkg::UVP_VCC_INTER;
            VPP_SEL <= fast ? uvp_pkg::UVP_VPP_FAST : uvp_pkg::UVP_VPP_PROG;
         end
      end
   end
endmodule

// ==== dv/uvp_prom_model.sv ====
// behavioural model of the uv-erasable prom on the pins
module uvp_prom_model #(
   parameter logic [7:0] MAKER_CODE  = 8'h25, // arbitrary value, odd parity
   parameter logic [7:0] DEVICE_CODE = 8'h13  // arbitrary value, odd parity
) (
   // memory pins
   input  wire logic [16:0] word_address_lines,
   input  wire logic        id_high_voltage,
   input  wire logic        chip_select_n,
   input  wire logic        output_gate_n,
   input  wire logic        program_strobe_n,
   input  wire logic [7:0]  byte_lines,
   input  wire logic [1:0]  vpp_sel,
   output logic [7:0]       q,
   output logic             q_oe,
   // test controls
   input  wire logic        erase,
   input  wire logic [16:0] slow_addr,
   input  wire logic [4:0]  slow_need
);
   logic [7:0] mem [0:131071];
   int         pulses [0:131071];
   logic [7:0] last_q = 8'h00;
   logic [7:0] drv;
   logic       prog_mode;
   int         need;

   always @(posedge erase)
   begin
      for (int i = 0; i < 131072; i++)
      begin
         mem[i] = 8'hFF;
         pulses[i] = 0;
      end
   end

   assign prog_mode = vpp_sel != 2'h0 && output_gate_n && !chip_select_n;
   assign need = (word_address_lines == slow_addr) ? int'(slow_need) : 1;

   always @(negedge program_strobe_n)
   begin
      if (prog_mode)
      begin
         pulses[word_address_lines]++;
         if (pulses[word_address_lines] >= need)
            mem[word_address_lines] = mem[word_address_lines] & byte_lines;
      end
   end

   assign drv = id_high_voltage ? (word_address_lines[0] ? DEVICE_CODE : MAKER_CODE) : mem[word_address_lines];
   assign q_oe = !chip_select_n && !output_gate_n && (program_strobe_n || vpp_sel == 2'h0);
   // floating lines show the inverse of the last value
   assign q = q_oe ? drv : ~last_q;

   always @(q_oe or drv)
   begin
      if (q_oe)
         last_q = drv;
   end
endmodule

// ==== dv/uvp_asserts.sv ====
// pin-level checker for the prom programmer
module uvp_asserts #(
   parameter int FAST_PW  = 5,
   parameter int INTER_PW = 5,
   parameter int OVER_PW  = 10
) (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST,
   // watched ports
   input wire logic        BUSY,
   input wire logic [16:0] WORD_ADDRESS_LINES,
   input wire logic        ID_HIGH_VOLTAGE,
   input wire logic        CHIP_SELECT_N,
   input wire logic        OUTPUT_GATE_N,
   input wire logic        PROGRAM_STROBE_N,
   input wire logic        BYTE_LINES_OE,
   input wire logic [1:0]  VCC_SEL,
   input wire logic [1:0]  VPP_SEL
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   logic [15:0] low_cnt;

   // length of the current strobe pulse
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         low_cnt <= 16'h0000;
      else if (!PROGRAM_STROBE_N)
         low_cnt <= low_cnt + 16'h0001;
      else
         low_cnt <= 16'h0000;
   end

   property p_pmode;
      !PROGRAM_STROBE_N |-> !CHIP_SELECT_N && OUTPUT_GATE_N && VPP_SEL != 2'h0 && BYTE_LINES_OE;
   endproperty
   a_pmode: assert property (p_pmode) else $error("strobe low outside program mode");

   property p_float;
      !OUTPUT_GATE_N |-> !BYTE_LINES_OE;
   endproperty
   a_float: assert property (p_float) else $error("byte lines driven while gate low");

   property p_stable;
      !PROGRAM_STROBE_N |-> $stable(WORD_ADDRESS_LINES);
   endproperty
   a_stable: assert property (p_stable) else $error("address moved during pulse");

   property p_fast_pw;
      $rose(PROGRAM_STROBE_N) && VCC_SEL == 2'h2 |-> low_cnt == FAST_PW;
   endproperty
   a_fast_pw: assert property (p_fast_pw) else $error("fast pulse width wrong");

   property p_inter_pw;
      $rose(PROGRAM_STROBE_N) && VCC_SEL == 2'h1 |-> low_cnt == INTER_PW || low_cnt == OVER_PW;
   endproperty
   a_inter_pw: assert property (p_inter_pw) else $error("interactive pulse width wrong");

   property p_fast_sup;
      $fell(PROGRAM_STROBE_N) && VPP_SEL == 2'h2 |-> VCC_SEL == 2'h2 && $past(PROGRAM_STROBE_N, 2);
   endproperty
   a_fast_sup: assert property (p_fast_sup) else $error("fast pulse without fast supplies");

   property p_inter_sup;
      $fell(PROGRAM_STROBE_N) && VPP_SEL == 2'h1 |-> VCC_SEL == 2'h1;
   endproperty
   a_inter_sup: assert property (p_inter_sup) else $error("interactive pulse at normal core");

   property p_id;
      ID_HIGH_VOLTAGE |-> WORD_ADDRESS_LINES[16:10] == 7'h00 && WORD_ADDRESS_LINES[8:1] == 8'h00;
   endproperty
   a_id: assert property (p_id) else $error("address lines not low in identify");

   property p_idle;
      !BUSY ##1 !BUSY |-> CHIP_SELECT_N && PROGRAM_STROBE_N;
   endproperty
   a_idle: assert property (p_idle) else $error("memory selected while idle");

   c_fast: cover property ($fell(PROGRAM_STROBE_N) && VCC_SEL == 2'h2);
   c_inter: cover property ($fell(PROGRAM_STROBE_N) && VCC_SEL == 2'h1);
   c_id: cover property (ID_HIGH_VOLTAGE);
endmodule

bind uvp_programmer uvp_asserts #(.FAST_PW(FAST_PW), .INTER_PW(INTER_PW), .OVER_PW(OVER_PW)) u_chk (
   .CLK(CLK), .RST(RST), .BUSY(BUSY), .WORD_ADDRESS_LINES(WORD_ADDRESS_LINES),
   .ID_HIGH_VOLTAGE(ID_HIGH_VOLTAGE), .CHIP_SELECT_N(CHIP_SELECT_N), .OUTPUT_GATE_N(OUTPUT_GATE_N),
   .PROGRAM_STROBE_N(PROGRAM_STROBE_N), .BYTE_LINES_OE(BYTE_LINES_OE), .VCC_SEL(VCC_SEL), .VPP_SEL(VPP_SEL));

// ==== dv/tb_top.sv ====
// testbench for the prom programmer with a device model
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, start, busy, done, fail, id_hv, cs_n, oe_n, pgm_n, byte_oe, id_ok, erase;
   logic [1:0]  op, vcc_sel, vpp_sel;
   logic [16:0] rd_addr, fail_addr, src_addr, addr_lines, slow_addr;
   logic [7:0]  rd_data, id_maker, id_device, src_data, byte_out, byte_in, mdl_q, inh_q;
   logic [4:0]  slow_need;
   logic        mdl_oe, inh_oe;
   int          errors, checked;

   // byte source and resolved data lines
   assign src_data = 8'h5A ^ src_addr[7:0];
   assign byte_in = byte_oe ? byte_out : mdl_q;

   uvp_programmer #(.FAST_PW(5), .INTER_PW(5), .OVER_PW(10), .SETUP(2), .LAST(17'h0_0003)) dut (
      .CLK(clk), .RST(rst), .START(start), .OP(op), .RD_ADDR(rd_addr), .BUSY(busy), .DONE(done),
      .FAIL(fail), .FAIL_ADDR(fail_addr), .RD_DATA(rd_data), .ID_MAKER(id_maker), .ID_DEVICE(id_device),
      .ID_PARITY_OK(id_ok), .SRC_ADDR(src_addr), .SRC_DATA(src_data), .WORD_ADDRESS_LINES(addr_lines),
      .ID_HIGH_VOLTAGE(id_hv), .CHIP_SELECT_N(cs_n), .OUTPUT_GATE_N(oe_n), .PROGRAM_STROBE_N(pgm_n),
      .BYTE_LINES_IN(byte_in), .BYTE_LINES_OUT(byte_out), .BYTE_LINES_OE(byte_oe),
      .VCC_SEL(vcc_sel), .VPP_SEL(vpp_sel));

   uvp_prom_model mdl (.word_address_lines(addr_lines), .id_high_voltage(id_hv), .chip_select_n(cs_n),
      .output_gate_n(oe_n), .program_strobe_n(pgm_n), .byte_lines(byte_in), .vpp_sel(vpp_sel), .q(mdl_q),
      .q_oe(mdl_oe), .erase(erase), .slow_addr(slow_addr), .slow_need(slow_need));

   // second memory on shared lines, selected only while the first is not
   uvp_prom_model inh (.word_address_lines(addr_lines), .id_high_voltage(id_hv), .chip_select_n(!cs_n),
      .output_gate_n(oe_n), .program_strobe_n(pgm_n), .byte_lines(byte_in), .vpp_sel(vpp_sel), .q(inh_q),
      .q_oe(inh_oe), .erase(erase), .slow_addr(slow_addr), .slow_need(slow_need));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic check_count(input int got, input int exp, input string what);
      checked++;
      if (got != exp)
      begin
         errors++;
         $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // fresh memory with one slow address
   task automatic prep(input logic [16:0] a, input logic [4:0] n);
      @(posedge clk);
      #1;
      erase = 1'b1;
      slow_addr = a;
      slow_need = n;
      @(posedge clk);
      #1;
      erase = 1'b0;
   endtask

   task automatic run_op(input logic [1:0] kind, input logic [16:0] a);
      int n;
      @(posedge clk);
      #1;
      op = kind;
      rd_addr = a;
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(17'(done), 17'h0_0001, "done");
   endtask

   task automatic t_reset();
      check({12'h000, cs_n, oe_n, pgm_n, byte_oe, busy}, 17'h0_001C, "pins at reset");
      check({9'h000, rd_data}, 17'h0_00FF, "read data at reset");
      check({13'h0000, vcc_sel, vpp_sel}, 17'h0_0000, "supplies at reset");
   endtask

   task automatic t_read_erased();
      prep(17'h0_0000, 5'h01);
      run_op(2'h3, 17'h1_FFFF);
      check({9'h000, rd_data}, 17'h0_00FF, "erased byte");
   endtask

   task automatic t_identify();
      run_op(2'h2, 17'h0_0000);
      check({9'h000, id_maker}, 17'h0_0025, "maker byte");
      check({9'h000, id_device}, 17'h0_0013, "device byte");
      check(17'(id_ok), 17'h0_0001, "id parity");
   endtask

   task automatic t_program(input logic [1:0] kind, input int extra);
      prep(17'h0_0001, 5'h19);
      run_op(kind, 17'h0_0000);
      check(17'(fail), 17'h0_0000, "no failure");
      check_count(mdl.pulses[1], 25 + extra, "pulses at slow address");
      check_count(mdl.pulses[0], 1 + extra, "pulses at plain address");
      check_count(inh.pulses[1], 0, "inhibited memory pulses");
      for (int a = 0; a < 4; a++)
      begin
         run_op(2'h3, 17'(a));
         check({9'h000, rd_data}, 17'(8'h5A ^ 8'(a)), "programmed byte");
      end
   endtask

   task automatic t_fail(input logic [1:0] kind);
      prep(17'h0_0002, 5'h1E);
      run_op(kind, 17'h0_0000);
      check(17'(fail), 17'h0_0001, "failure flagged");
      check(fail_addr, 17'h0_0002, "failing address");
      check_count(mdl.pulses[2], 25, "pulse limit");
      check_count(mdl.pulses[3], 0, "aborted after limit");
      run_op(2'h3, 17'h0_0000);
      check(17'(fail), 17'h0_0000, "failure cleared");
   endtask

   // watchdog
   initial
   begin
      #4_000_000;
      errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      complete_run();
   end

   initial
   begin
      rst = 1'b1;
      start = 1'b0;
      op = 2'h0;
      rd_addr = 17'h0_0000;
      erase = 1'b0;
      slow_addr = 17'h0_0000;
      slow_need = 5'h01;
      errors = 0;
      checked = 0;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_read_erased();
      t_identify();
      t_program(2'h1, 0);
      t_program(2'h0, 1);
      t_fail(2'h1);
      t_fail(2'h0);
      complete_run();
   end
endmodule
